// >>> logic/acces_ctrl.v
// Converter enable, soft reset and halt control with Wishbone registers
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`include "acces_defines.vh"
module acces_ctrl (
	// Clock and reset
	input  wire        CORE_CLK,
	input  wire        RST,
	// Wishbone slave
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [5:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output wire [31:0] WB_DAT_O,
	output wire        WB_ACK_O,
	// System modes and converter events
	input  wire        FREEZE_MODE,
	input  wire        WAIT_MODE,
	input  wire        TRIGGER,
	input  wire        SEVERE_ERROR,
	input  wire        OVERRUN,
	// Converter control outputs
	output reg         CONV_POWER,
	output reg         CONV_ACTIVE,
	output reg         RESULT_STORE,
	output reg         RESULT_DISCARD,
	output reg         FLOW_TRIGGER_MODE,
	output reg  [1:0]  FLOW_ACCESS,
	output reg         IRQ
);
	// Engine states
	localparam ST_OFF  = 3'd0;
	localparam ST_REC  = 3'd1;
	localparam ST_IDLE = 3'd2;
	localparam ST_CONV = 3'd3;
	localparam ST_HALT = 3'd4;
	localparam ST_DIS  = 3'd5;
	localparam ST_ERR  = 3'd6;

	reg  [2:0]              state;
	reg  [2:0]              next_state;
	reg  [15:0]             ctrl;
	reg                     special_mode_write_access;
	reg                     cmd_list_sel;
	reg                     res_list_sel;
	reg  [`ACCES_IDX_W-1:0] cmd_idx;
	reg  [`ACCES_IDX_W-1:0] res_idx;
	reg                     overrun_flag;
	reg                     error_flag;
	reg  [`ACCES_IRQ_W-1:0] irq_stat;
	reg  [`ACCES_IRQ_W-1:0] irq_en;
	reg  [31:0]             rdata;
	reg                     tim_load;
	reg  [`ACCES_CNT_W-1:0] tim_value;
	reg  [`ACCES_IRQ_W-1:0] ev;
	wire                    wr_stb;
	wire                    rd_stb;
	wire                    tim_busy;
	wire                    en_bit;
	wire                    sr_bit;
	wire                    halt_req;
	wire                    cfg_wr_ok;
	wire [15:0]             wdat;
	wire                    ctrl_wr;
	wire                    cfg_wr;
	wire                    clr_wr;
	wire                    ien_wr;

	// Byte lane merge for the 16-bit control word
	function [15:0] lane_merge;
		input [15:0] old;
		input [15:0] neu;
		input [1:0]  sel;
		begin
			lane_merge = {sel[1] ? neu[15:8] : old[15:8], sel[0] ? neu[7:0] : old[7:0]};
		end
	endfunction

	// Register write decode, shared by every writable register
	function wr_hit;
		input       hit_stb;
		input [5:0] hit_adr;
		input [5:0] hit_target;
		begin
			wr_hit = hit_stb && (hit_adr == hit_target);
		end
	endfunction

	assign en_bit    = ctrl[`ACCES_EN_BIT];
	assign sr_bit    = ctrl[`ACCES_SR_BIT];
	assign wdat      = lane_merge(ctrl, WB_DAT_I[15:0], WB_SEL_I[1:0]);
	assign cfg_wr_ok = ~en_bit | special_mode_write_access;
	// Halt only at a conversion boundary, gated by the freeze and wait options
	assign halt_req  = (FREEZE_MODE & ctrl[`ACCES_FRZ_BIT])
	                 | (WAIT_MODE & ctrl[`ACCES_WAI_BIT]);

	// One decode per writable register; byte lane 0 gates the narrow registers
	assign ctrl_wr   = wr_hit(wr_stb, WB_ADR_I, `ACCES_CTRL_ADDR);
	assign cfg_wr    = wr_hit(wr_stb, WB_ADR_I, `ACCES_CFG_ADDR) & WB_SEL_I[0];
	assign clr_wr    = wr_hit(wr_stb, WB_ADR_I, `ACCES_IRQ_CLR_ADDR) & WB_SEL_I[0];
	assign ien_wr    = wr_hit(wr_stb, WB_ADR_I, `ACCES_IRQ_EN_ADDR) & WB_SEL_I[0];

	acces_wb_slave u_bus (
		.clk      (CORE_CLK),
		.rst      (RST),
		.cyc      (WB_CYC_I),
		.stb      (WB_STB_I),
		.we       (WB_WE_I),
		.adr      (WB_ADR_I),
		.rdata_in (rdata),
		.ack      (WB_ACK_O),
		.dat_o    (WB_DAT_O),
		.wr_stb   (wr_stb),
		.rd_stb   (rd_stb)
	);

	acces_timer u_timer (
		.clk   (CORE_CLK),
		.rst   (RST),
		.load  (tim_load),
		.value (tim_value),
		.busy  (tim_busy)
	);

	// Read mux; unmapped addresses read zero
	always @* begin
		case (WB_ADR_I)
		`ACCES_CTRL_ADDR:     rdata = {16'h0000, ctrl};
		`ACCES_STAT_ADDR:     rdata = {24'h000000, res_list_sel, cmd_list_sel,
		                               overrun_flag, error_flag, state, tim_busy};
		`ACCES_IRQ_STAT_ADDR: rdata = {{(32-`ACCES_IRQ_W){1'b0}}, irq_stat};
		`ACCES_IRQ_EN_ADDR:   rdata = {{(32-`ACCES_IRQ_W){1'b0}}, irq_en};
		`ACCES_IDX_ADDR:      rdata = {18'h00000, res_idx, 2'b00, cmd_idx};
		`ACCES_CFG_ADDR:      rdata = {31'h00000000, special_mode_write_access};
		default:              rdata = 32'h0000_0000;
		endcase
	end

	// Engine next state
	always @* begin
		next_state = state;
		tim_load   = 1'b0;
		tim_value  = {`ACCES_CNT_W{1'b0}};
		case (state)
		ST_OFF: begin
			if (en_bit) begin
				next_state = ST_REC;
				tim_load   = 1'b1;
				tim_value  = `ACCES_RECOVERY_PERIOD_CYC;
			end
		end
		ST_REC: begin
			if (!en_bit)
				next_state = ST_OFF;
			else if (!tim_busy)
				next_state = ST_IDLE;
		end
		ST_IDLE, ST_HALT: begin
			if (!en_bit) begin
				next_state = ST_DIS;
				tim_load   = 1'b1;
				tim_value  = `ACCES_TDIS_CYC;
			end else if (halt_req)
				next_state = ST_HALT;
			else if (state == ST_HALT)
				next_state = ST_IDLE;
			else if (TRIGGER) begin
				next_state = ST_CONV;
				tim_load   = 1'b1;
				tim_value  = `ACCES_CONV_CYC;
			end
		end
		ST_CONV: begin
			if (!en_bit) begin
				next_state = ST_DIS;
				tim_load   = 1'b1;
				tim_value  = `ACCES_TDIS_CYC;
			end else if (!tim_busy) begin
				if (halt_req)
					next_state = ST_HALT;
				else if (FLOW_TRIGGER_MODE)
					next_state = ST_IDLE;
				else begin
					tim_load  = 1'b1;
					tim_value = `ACCES_CONV_CYC;
				end
			end
		end
		ST_DIS: begin
			if (!tim_busy)
				next_state = ST_OFF;
		end
		ST_ERR: begin
			next_state = ST_ERR;
		end
		default: next_state = ST_OFF;
		endcase
		if (SEVERE_ERROR && state != ST_OFF && state != ST_DIS)
			next_state = ST_ERR;
		if (sr_bit) begin
			next_state = en_bit ? ST_IDLE : ST_OFF;
			tim_load   = 1'b0;
		end
	end

	// Interrupt events of this cycle
	always @* begin
		ev = {`ACCES_IRQ_W{1'b0}};
		ev[`ACCES_IRQ_SEVERE] = (next_state == ST_ERR) && (state != ST_ERR);
		// A conversion cut by disable never completes, so its result is dropped
		ev[`ACCES_IRQ_DONE]   = (state == ST_CONV) && !tim_busy && en_bit && !sr_bit;
		ev[`ACCES_IRQ_SRDONE] = sr_bit;
	end

	// Control register; soft reset cannot be cleared by a write
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ctrl     <= `ACCES_CTRL_RESET;
			special_mode_write_access <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				ctrl[15:12] <= {wdat[15], wdat[14] | sr_bit, wdat[13:12]};
				if (cfg_wr_ok)
					ctrl[11:8] <= wdat[11:8];
			end
			// Hardware clears the bit once the soft reset has run
			if (sr_bit)
				ctrl[`ACCES_SR_BIT] <= 1'b0;
			// Re-enable is refused while the disable latency runs
			if (state == ST_DIS && !(ctrl_wr && !wdat[15]))
				ctrl[`ACCES_EN_BIT] <= 1'b0;
			if (cfg_wr)
				special_mode_write_access <= WB_DAT_I[`ACCES_SMOD_BIT];
		end
	end

	// Engine state, indices, flags and list selects
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state        <= ST_OFF;
			cmd_idx      <= {`ACCES_IDX_W{1'b0}};
			res_idx      <= {`ACCES_IDX_W{1'b0}};
			cmd_list_sel <= 1'b0;
			res_list_sel <= 1'b0;
			overrun_flag <= 1'b0;
			error_flag   <= 1'b0;
		end else begin
			state <= next_state;
			if (sr_bit) begin
				cmd_idx      <= {`ACCES_IDX_W{1'b0}};
				res_idx      <= {`ACCES_IDX_W{1'b0}};
				cmd_list_sel <= 1'b0;
				res_list_sel <= 1'b0;
				overrun_flag <= 1'b0;
				error_flag   <= 1'b0;
			end else begin
				if (OVERRUN)
					overrun_flag <= 1'b1;
				if (ev[`ACCES_IRQ_SEVERE])
					error_flag <= 1'b1;
				if (ev[`ACCES_IRQ_DONE]) begin
					cmd_idx <= cmd_idx + 1'b1;
					res_idx <= res_idx + 1'b1;
				end
			end
		end
	end

	// Sticky interrupt status: a new event beats a clear in the same cycle
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			irq_stat <= {`ACCES_IRQ_W{1'b0}};
			irq_en   <= {`ACCES_IRQ_W{1'b0}};
		end else begin
			// Clear is write-one, so a zero in the data never touches a pending bit
			if (clr_wr)
				irq_stat <= (irq_stat & ~WB_DAT_I[`ACCES_IRQ_W-1:0]) | ev;
			else
				irq_stat <= irq_stat | ev;
			if (ien_wr)
				irq_en <= WB_DAT_I[`ACCES_IRQ_W-1:0];
		end
	end

	// Registered outputs; power and active derived from next state so they track the engine exactly
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			CONV_POWER        <= 1'b0;
			CONV_ACTIVE       <= 1'b0;
			RESULT_STORE      <= 1'b0;
			RESULT_DISCARD    <= 1'b0;
			FLOW_TRIGGER_MODE <= 1'b0;
			FLOW_ACCESS       <= 2'b00;
			IRQ               <= 1'b0;
		end else begin
			CONV_POWER        <= (next_state != ST_OFF) && (next_state != ST_DIS);
			CONV_ACTIVE       <= (next_state == ST_CONV);
			RESULT_STORE      <= ev[`ACCES_IRQ_DONE];
			RESULT_DISCARD    <= (state == ST_CONV) && (next_state == ST_DIS);
			FLOW_TRIGGER_MODE <= ctrl[`ACCES_MODE_BIT];
			FLOW_ACCESS       <= ctrl[`ACCES_ACC_HI:`ACCES_ACC_LO];
			// Built from the next status so the line drops together with a clear
			IRQ               <= |(((irq_stat | ev) & ~({`ACCES_IRQ_W{clr_wr}}
			                     & WB_DAT_I[`ACCES_IRQ_W-1:0] & ~ev)) & irq_en);
		end
	end
endmodule // acces_ctrl

// >>> logic/acces_defines.vh
// Constants for the converter enable and soft-reset control block
// Function
// - Enable, soft-reset, freeze-option and wait-option bits accept writes at any time and the register reads at any time.
// - Flow-mode, store-on-abort and flow-access bits change only while enable is clear or special-mode access is set.
// - Setting enable powers the converter; clearing it aborts the running sequence and discards results.
// - After disable, re-enable is refused until pending actions finish or abort, within the disable latency.
// - Writing 1 to soft reset clears overrun and error flags and returns the engine to idle; writing 0 does nothing.
// - Soft reset also zeroes command and result indices and clears both list-select bits.
// - A set soft-reset bit ignores clearing writes and is cleared by hardware when the reset is done.
// - A severe error stops the converter until software issues a soft reset.
// - Freeze option 1 halts at the next conversion boundary in debug freeze; 0 keeps converting.
// - Wait option 1 halts at the next conversion boundary in wait mode; 0 keeps converting.
// - Flow-mode bit selects restart mode at 0 and trigger mode at 1.
// - Flow-access bits reset to 00 (no path); 01 internal only, 10 data bus only.
`ifndef ACCES_DEFINES_VH
`define ACCES_DEFINES_VH
// Register byte addresses
`define ACCES_CTRL_ADDR      6'h00
`define ACCES_STAT_ADDR      6'h04
`define ACCES_IRQ_STAT_ADDR  6'h08
`define ACCES_IRQ_CLR_ADDR   6'h0c
`define ACCES_IRQ_EN_ADDR    6'h10
`define ACCES_IDX_ADDR       6'h14
`define ACCES_CFG_ADDR       6'h18
// Main control field positions
`define ACCES_EN_BIT         15
`define ACCES_SR_BIT         14
`define ACCES_FRZ_BIT        13
`define ACCES_WAI_BIT        12
`define ACCES_ACC_HI         11
`define ACCES_ACC_LO         10
`define ACCES_SEQA_BIT       9
`define ACCES_MODE_BIT       8
`define ACCES_CTRL_RESET     16'h0000
// Auxiliary config register: bit 0 special-mode write access
`define ACCES_SMOD_BIT       0
// Interrupt status bits
`define ACCES_IRQ_SEVERE     0
`define ACCES_IRQ_DONE       1
`define ACCES_IRQ_SRDONE     2
`define ACCES_IRQ_W          3
// Timing: disable latency and recovery period in ns, clock period 100 ns
`define ACCES_CLK_NS         100
`define ACCES_TDIS_NS        1000
`define ACCES_RECOVERY_PERIOD_NS        2000
// The same periods as timer loads, sized to the counter so no load is truncated
`define ACCES_TDIS_CYC       8'h0a
`define ACCES_RECOVERY_PERIOD_CYC       8'h14
// Conversion length in cycles
`define ACCES_CONV_CYC       8'h10
`define ACCES_CNT_W          8
`define ACCES_IDX_W          6
`endif

// >>> logic/acces_timer.v
// Down counter used for disable latency, recovery and conversion timing
`timescale 1ns/1ps
`include "acces_defines.vh"
module acces_timer (
	// Clock and reset
	input  wire                    clk,
	input  wire                    rst,
	// Control
	input  wire                    load,
	input  wire [`ACCES_CNT_W-1:0] value,
	// Status
	output reg                     busy
);
	reg [`ACCES_CNT_W-1:0] count;

	// Load wins over counting so a restart is never lost
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= {`ACCES_CNT_W{1'b0}};
			busy  <= 1'b0;
		end else if (load) begin
			count <= value;
			busy  <= (value != {`ACCES_CNT_W{1'b0}});
		end else if (count != {`ACCES_CNT_W{1'b0}}) begin
			count <= count - 1'b1;
			busy  <= (count != {{(`ACCES_CNT_W-1){1'b0}}, 1'b1});
		end
	end
endmodule // acces_timer

// >>> logic/acces_wb_slave.v
// Classic Wishbone slave front end: one-cycle registered ack
`timescale 1ns/1ps
`include "acces_defines.vh"
module acces_wb_slave (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Wishbone
	input  wire        cyc,
	input  wire        stb,
	input  wire        we,
	input  wire [5:0]  adr,
	input  wire [31:0] rdata_in,
	output reg         ack,
	output reg  [31:0] dat_o,
	// Register file strobes
	output wire        wr_stb,
	output wire        rd_stb
);
	// Access is accepted on the first cycle of a request; ack drops the next cycle
	assign wr_stb = cyc & stb & we & ~ack;
	assign rd_stb = cyc & stb & ~we & ~ack;

	// Ack and read data registered together
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ack   <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack <= cyc & stb & ~ack;
			if (rd_stb)
				dat_o <= rdata_in;
		end
	end
endmodule // acces_wb_slave

// >>> dv/acces_ctrl_checker.sv
// Assertion checker for the converter control block
`timescale 1ns/1ps
module acces_ctrl_checker (
	// Clock, reset and bus
	input wire       CORE_CLK,
	input wire       RST,
	input wire       WB_CYC_I,
	input wire       WB_STB_I,
	input wire       WB_WE_I,
	input wire [5:0] WB_ADR_I,
	input wire       WB_ACK_O,
	// Converter side
	input wire       SEVERE_ERROR,
	input wire       CONV_POWER,
	input wire       CONV_ACTIVE,
	input wire       RESULT_STORE,
	input wire       RESULT_DISCARD,
	input wire       FLOW_TRIGGER_MODE,
	input wire [1:0] FLOW_ACCESS
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// Control write seen at the acknowledging edge; config outputs move one cycle later
	wire ctl_wr = WB_ACK_O && WB_WE_I && WB_ADR_I == 6'h00;
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not answered next cycle");
	a_mode_write: assert property ($changed(FLOW_TRIGGER_MODE) |-> $past(ctl_wr))
		else $error("flow mode moved without a write");
	a_access_write: assert property ($changed(FLOW_ACCESS) |-> $past(ctl_wr))
		else $error("flow access moved without a write");
	a_discard_only: assert property (RESULT_DISCARD |-> !RESULT_STORE &&
		($past(CONV_ACTIVE) || $past(CONV_ACTIVE, 2))) else $error("bad discard");
	a_off_idle: assert property (!CONV_POWER |-> !CONV_ACTIVE)
		else $error("converting while unpowered");
	a_recovery_hold: assert property ($rose(CONV_POWER) |-> !CONV_ACTIVE[*8])
		else $error("conversion during recovery");
	a_disable_hold: assert property ($fell(CONV_POWER) |-> !CONV_POWER[*8])
		else $error("re-enabled inside disable latency");
	a_severe_stop: assert property (SEVERE_ERROR |-> ##[1:2] !CONV_ACTIVE)
		else $error("severe error did not stop conversion");
endmodule // acces_ctrl_checker

bind acces_ctrl acces_ctrl_checker acces_ctrl_checker_i (.CORE_CLK, .RST, .WB_CYC_I,
	.WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_ACK_O, .SEVERE_ERROR, .CONV_POWER, .CONV_ACTIVE,
	.RESULT_STORE, .RESULT_DISCARD, .FLOW_TRIGGER_MODE, .FLOW_ACCESS);

// >>> dv/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
	reg         clk, rst, cyc, stb, we, frz, wai, trig, sev, ovr;
	reg  [5:0]  adr;
	reg  [3:0]  sel;
	reg  [31:0] wdat, rd;
	wire [31:0] rdat;
	wire        ack, pwr, act, sto, dis, tmode, irq;
	wire [1:0]  facc;
	integer     err_total, checked, n, i, ndis, nsto;
	acces_ctrl acces_ctrl_i (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .FREEZE_MODE(frz), .WAIT_MODE(wai), .TRIGGER(trig),
		.SEVERE_ERROR(sev), .OVERRUN(ovr), .CONV_POWER(pwr), .CONV_ACTIVE(act),
		.RESULT_STORE(sto), .RESULT_DISCARD(dis), .FLOW_TRIGGER_MODE(tmode),
		.FLOW_ACCESS(facc), .IRQ(irq));
	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Result pulses are one cycle wide, so they are counted as they pass
	always @(posedge clk) begin
		if (dis === 1'b1) ndis = ndis + 1;
		if (sto === 1'b1) nsto = nsto + 1;
	end
	task final_report;
		begin
			$display("checks %0d errors %0d", checked, err_total);
			if (err_total == 0 && checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task tmo;
		begin
			err_total = err_total + 1;
			final_report;
		end
	endtask
	task chk(input [127:0] nm, input [31:0] exp, input [31:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("ERROR %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task waitc(input integer k);
		repeat (k) @(posedge clk);
	endtask
	// Classic cycle: raise after an edge, hold until ack is sampled, then release
	task wb(input w, input [5:0] a, input [31:0] d);
		begin
			@(posedge clk);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			sel <= 4'h3;
			wdat <= d;
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (ack !== 1'b1 && n < 20);
			rd = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
			if (ack !== 1'b1) tmo;
		end
	endtask
	task conv_start;
		begin
			@(posedge clk);
			trig <= 1'b1;
			@(posedge clk);
			trig <= 1'b0;
			n = 0;
			while (act !== 1'b1 && n < 40) begin
				@(posedge clk);
				n = n + 1;
			end
			if (act !== 1'b1) tmo;
		end
	endtask
	task t_reg;
		begin
			wb(1'b0, 6'h00, 32'h0);
			chk("ctrl reset", 32'h0, rd);
			chk("access reset", 32'h0, 32'(facc));
			wb(1'b0, 6'h3c, 32'h0);
			chk("unmapped", 32'h0, rd);
			$display("t_reg done");
		end
	endtask
	task t_cfg;
		begin
			wb(1'b1, 6'h00, 32'h3500);
			wb(1'b0, 6'h00, 32'h0);
			chk("ctrl", 32'h3500, rd);
			chk("mode", 32'h1, 32'(tmode));
			chk("access", 32'h1, 32'(facc));
			wb(1'b1, 6'h00, 32'h8500);
			wb(1'b1, 6'h00, 32'h8a00);
			wb(1'b0, 6'h00, 32'h0);
			chk("locked", 32'h8500, rd);
			wb(1'b1, 6'h18, 32'h1);
			wb(1'b1, 6'h00, 32'h8a00);
			waitc(1);
			chk("access", 32'h2, 32'(facc));
			chk("mode", 32'h0, 32'(tmode));
			wb(1'b1, 6'h18, 32'h0);
			$display("t_cfg done");
		end
	endtask
	task t_abort;
		begin
			waitc(20);
			conv_start;
			ndis = 0;
			nsto = 0;
			wb(1'b1, 6'h00, 32'h0);
			waitc(2);
			chk("discard", 32'h1, ndis);
			chk("store", 32'h0, nsto);
			chk("power", 32'h0, 32'(pwr));
			wb(1'b1, 6'h00, 32'h8000);
			wb(1'b0, 6'h00, 32'h0);
			chk("early enable", 32'h0, 32'(rd[15]));
			waitc(12);
			wb(1'b1, 6'h00, 32'h8000);
			wb(1'b0, 6'h00, 32'h0);
			chk("enable", 32'h1, 32'(rd[15]));
			$display("t_abort done");
		end
	endtask
	task t_sev;
		begin
			waitc(20);
			sev <= 1'b1;
			ovr <= 1'b1;
			@(posedge clk);
			sev <= 1'b0;
			ovr <= 1'b0;
			@(posedge clk);
			trig <= 1'b1;
			@(posedge clk);
			trig <= 1'b0;
			waitc(20);
			chk("stopped", 32'h0, 32'(act));
			wb(1'b1, 6'h00, 32'h8000);
			wb(1'b0, 6'h04, 32'h0);
			chk("error state", 32'h1e, 32'(rd[5:1]));
			chk("masked", 32'h0, 32'(irq));
			wb(1'b1, 6'h10, 32'h5);
			waitc(1);
			chk("irq raised", 32'h1, 32'(irq));
			wb(1'b1, 6'h00, 32'hc000);
			wb(1'b0, 6'h00, 32'h0);
			chk("self clear", 32'h8000, rd);
			wb(1'b0, 6'h04, 32'h0);
			chk("status", 32'h02, 32'(rd[7:1]));
			wb(1'b0, 6'h14, 32'h0);
			chk("indices", 32'h0, rd);
			wb(1'b0, 6'h08, 32'h0);
			chk("irq status", 32'h5, 32'(rd[2:0]));
			wb(1'b1, 6'h0c, 32'h5);
			waitc(1);
			chk("irq cleared", 32'h0, 32'(irq));
			conv_start;
			$display("t_sev done");
		end
	endtask
	// Option 0 must keep converting in the mode, option 1 must stop at a boundary
	task t_halt;
		begin
			for (i = 0; i < 2; i = i + 1) begin
				wb(1'b1, 6'h00, 32'h8000);
				conv_start;
				frz <= (i == 0);
				wai <= (i == 1);
				n = 0;
				nsto = 0;
				repeat (20) begin
					@(posedge clk);
					if (act === 1'b1) n = n + 1;
				end
				chk("continues", 32'h1, 32'(n > 10));
				chk("stores", 32'h1, 32'(nsto > 0));
				wb(1'b1, 6'h00, i ? 32'h9000 : 32'ha000);
				waitc(20);
				chk("halted", 32'h0, 32'(act));
				frz <= 1'b0;
				wai <= 1'b0;
				wb(1'b1, 6'h00, 32'hc000);
			end
			$display("t_halt done");
		end
	endtask
	// Trigger mode runs one conversion per trigger; a severe error stops a running one
	task t_trig;
		begin
			wb(1'b1, 6'h18, 32'h1);
			wb(1'b1, 6'h00, 32'h8100);
			wb(1'b1, 6'h18, 32'h0);
			wb(1'b1, 6'h0c, 32'h2);
			conv_start;
			nsto = 0;
			waitc(24);
			chk("one store", 32'h1, nsto);
			chk("trig idle", 32'h0, 32'(act));
			wb(1'b0, 6'h08, 32'h0);
			chk("done flag", 32'h1, 32'(rd[1]));
			conv_start;
			sev <= 1'b1;
			@(posedge clk);
			sev <= 1'b0;
			waitc(2);
			chk("severe stop", 32'h0, 32'(act));
			wb(1'b1, 6'h00, 32'hc100);
			conv_start;
			$display("t_trig done");
		end
	endtask
	initial begin
		{cyc, stb, we, frz, wai, trig, sev, ovr} = 8'h00;
		adr = 6'h00;
		sel = 4'h0;
		wdat = 32'h0;
		err_total = 0;
		checked = 0;
		ndis = 0;
		nsto = 0;
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reg;
		t_cfg;
		t_abort;
		t_sev;
		t_halt;
		t_trig;
		final_report;
	end
endmodule // tb_top
